// File: design/cac_capture_unit.sv
// One compare/capture module: pin edge capture, software-timer match and the capture register pair.
`timescale 1ns/1ns
`include "cac_cfg.svh"
module cac_capture_unit (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic module_external_pin,
   input wire cac_pkg::cac_mode_t mode,
   input wire logic [15:0] counter,
   input wire logic count_tick,
   input wire logic wr_cap_low,
   input wire logic wr_cap_high,
   input wire logic [7:0] wdata,
   output logic [15:0] capture,
   output logic module_event
);
   import cac_pkg::*;

   // Previous pin level, used to find edges.
   logic pin_prev;
   // Next capture register value.
   logic [15:0] next_capture;

   // Edge detection on the pin, qualified by the selected edge polarity.
   wire rise_hit = mode.cap_pos & ~pin_prev & module_external_pin;
   wire fall_hit = mode.cap_neg & pin_prev & ~module_external_pin;
   wire edge_hit = rise_hit | fall_hit;
   // Software-timer match counts only on a value the counter has just reached while running.
   wire match_hit = mode.compare_en & mode.match_en & count_tick & (counter == capture);

   // A capture is an ordinary event whatever its purpose.
   assign module_event = edge_hit | match_hit;

   // A captured edge takes all 16 counter bits at once and wins over a software byte write.
   assign next_capture = edge_hit ? counter :
                         wr_cap_high ? {wdata, capture[7:0]} :
                         wr_cap_low ? {capture[15:8], wdata} : capture;

   // Pin history and capture register.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         pin_prev <= 1'b1;
         capture <= `CAC_CNT_RESET;
      end else begin
         pin_prev <= module_external_pin;
         capture <= next_capture;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   // A falling edge with falling capture selected holds the whole counter of that cycle.
   AST_FALL_SNAPSHOT: assert property (
      (mode.cap_neg && pin_prev && !module_external_pin) |=> (capture == $past(counter)))
      else $error("falling-edge capture did not hold the counter value");

   // Any captured edge raises the module event in the same cycle.
   AST_CAPTURE_EVENT: assert property (
      (rise_hit || fall_hit) |-> module_event)
      else $error("capture edge gave no module event");

endmodule : cac_capture_unit

// File: design/cac_cfg.svh
// Address map, bit positions, reset values and counts for the counter array control block.
`ifndef CAC_CFG_SVH
`define CAC_CFG_SVH

// Byte addresses of the registers on the AHB-Lite bus.
`define CAC_CTRL_ADDR 32'h0000_00D8
`define CAC_CNT_LOW_ADDR 32'h0000_00E0
`define CAC_CNT_HIGH_ADDR 32'h0000_00E4
`define CAC_CMODE_ADDR 32'h0000_00E8
`define CAC_MOD_BASE 32'h0000_0100
`define CAC_MOD_LIMIT 32'h0000_0150
`define CAC_MOD_SHIFT 4

// Word selector inside one module's 16-byte window.
`define CAC_SUB_MODE 2'h0
`define CAC_SUB_CAP_LOW 2'h1
`define CAC_SUB_CAP_HIGH 2'h2

// Bit positions in the control/status register.
`define CAC_BIT_OVF 7
`define CAC_BIT_RUN 6
`define CAC_BIT_RSVD 5
`define CAC_EVT_MSB 4

// Bit position of the overflow interrupt enable in the counter mode register.
`define CAC_BIT_OVF_IE 0

// Reset values and counter limits.
`define CAC_CTRL_RESET 8'h00
`define CAC_CMODE_RESET 8'h00
`define CAC_CNT_RESET 16'h0000
`define CAC_CNT_MAX 16'hFFFF
`define CAC_CNT_ONE 16'h0001
`define CAC_RD_ZERO 32'h0000_0000

`endif

// File: design/cac_pkg.sv
// Shared types of the counter array control block.
package cac_pkg;

   // Per-module mode bits, packed low to high as int_en, match_en, compare_en, cap_neg, cap_pos.
   typedef struct packed {
      logic cap_pos;
      logic cap_neg;
      logic compare_en;
      logic match_en;
      logic int_en;
   } cac_mode_t;

   // Address phase of one AHB-Lite transfer, held for its data phase.
   typedef struct packed {
      logic [31:0] addr;
      logic write;
      logic valid;
   } cac_aphase_t;

endpackage : cac_pkg

// File: design/cac_top.sv
// Counter array control/status block: run control, overflow flag, module event flags, counter and capture map.
`timescale 1ns/1ns
`include "cac_cfg.svh"
module cac_top #(
   parameter int NUM_MODULES = 5
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [NUM_MODULES-1:0] module_external_pin,
   output logic counter_array_irq
);
   import cac_pkg::*;

   // Reset image of the control/status register, held as a sized constant so that single fields can be picked out.
   localparam logic [7:0] CTRL_RESET_VALUE = `CAC_CTRL_RESET;

   // True when an address lies in the per-module window.
   function automatic logic mod_hit(input logic [31:0] addr);
      mod_hit = (addr >= `CAC_MOD_BASE) && (addr < `CAC_MOD_LIMIT);
   endfunction : mod_hit

   // Module number of an address in the per-module window.
   function automatic logic [2:0] mod_index(input logic [31:0] addr);
      logic [31:0] offset;
      offset = (addr - `CAC_MOD_BASE) >> `CAC_MOD_SHIFT;
      mod_index = offset[2:0];
   endfunction : mod_index

   // Word inside a module's window.
   function automatic logic [1:0] mod_sub(input logic [31:0] addr);
      mod_sub = addr[3:2];
   endfunction : mod_sub

   // Address phase held over into the data phase.
   cac_aphase_t aphase;
   cac_aphase_t next_aphase;
   // Free-running counter and its next value.
   logic [15:0] counter;
   logic [15:0] next_counter;
   // Control/status fields.
   logic counter_overflow_flag;
   logic counter_run_bit;
   logic [NUM_MODULES-1:0] module_event_flag;
   logic next_overflow_flag;
   logic next_run_bit;
   logic [NUM_MODULES-1:0] next_event_flag;
   // Counter mode register, holding the overflow interrupt enable.
   logic [7:0] counter_mode_register;
   // Per-module modes, capture registers, events and interrupt enables.
   cac_mode_t module_mode [NUM_MODULES];
   logic [15:0] capture [NUM_MODULES];
   logic [NUM_MODULES-1:0] module_event;
   logic [NUM_MODULES-1:0] module_int_en;
   // Read data of the current address phase.
   logic [31:0] next_hrdata;

   // The slave never inserts wait states and always answers OKAY.
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // A transfer is taken when selected, the bus is ready and the transfer is NONSEQ or SEQ.
   wire addr_take = hsel & hready & htrans[1];
   assign next_aphase = '{addr: haddr, write: hwrite, valid: addr_take};

   // Address phase register.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         aphase <= '0;
      end else begin
         aphase <= next_aphase;
      end
   end

   // Write strobes, active in the data phase while hwdata stands.
   wire wr_en = aphase.valid & aphase.write;
   wire wr_ctrl = wr_en & (aphase.addr == `CAC_CTRL_ADDR);
   wire wr_cnt_low = wr_en & (aphase.addr == `CAC_CNT_LOW_ADDR);
   wire wr_cnt_high = wr_en & (aphase.addr == `CAC_CNT_HIGH_ADDR);
   wire wr_cmode = wr_en & (aphase.addr == `CAC_CMODE_ADDR);
   wire wr_mod = wr_en & mod_hit(aphase.addr);
   wire [2:0] wr_idx = mod_index(aphase.addr);
   wire [1:0] wr_sub = mod_sub(aphase.addr);
   wire [7:0] wbyte = hwdata[7:0];

   // The counter advances on each clock while running; a byte write replaces its byte instead.
   wire cnt_write = wr_cnt_low | wr_cnt_high;
   wire count_tick = counter_run_bit & ~cnt_write;
   // Rolling over from all ones to zero marks an overflow.
   wire cnt_wrap = count_tick & (counter == `CAC_CNT_MAX);

   // Next counter value: software byte writes at any time, else count while running.
   assign next_counter = wr_cnt_low ? {counter[15:8], wbyte} :
                         wr_cnt_high ? {wbyte, counter[7:0]} :
                         count_tick ? counter + `CAC_CNT_ONE : counter;

   // Counter register.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         counter <= `CAC_CNT_RESET;
      end else begin
         counter <= next_counter;
      end
   end

   // Overflow flag: a write of one sets it, a write of zero clears it, a rollover sets it and wins.
   assign next_overflow_flag = cnt_wrap |
                               (wr_ctrl ? hwdata[`CAC_BIT_OVF] : counter_overflow_flag);
   // Run bit follows software only.
   assign next_run_bit = wr_ctrl ? hwdata[`CAC_BIT_RUN] : counter_run_bit;
   // Event flags: a module event sets its flag even in the cycle software writes the register.
   assign next_event_flag = module_event |
                            (wr_ctrl ? hwdata[`CAC_EVT_MSB:0] : module_event_flag);

   // Control/status register; the reserved bit has no storage, so it is inactive from reset.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         counter_overflow_flag <= CTRL_RESET_VALUE[`CAC_BIT_OVF];
         counter_run_bit <= CTRL_RESET_VALUE[`CAC_BIT_RUN];
         module_event_flag <= CTRL_RESET_VALUE[`CAC_EVT_MSB:0];
      end else begin
         counter_overflow_flag <= next_overflow_flag;
         counter_run_bit <= next_run_bit;
         module_event_flag <= next_event_flag;
      end
   end

   // Counter mode register, holding the overflow interrupt enable.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         counter_mode_register <= `CAC_CMODE_RESET;
      end else if (wr_cmode) begin
         counter_mode_register <= wbyte;
      end
   end

   // Per-module mode registers and capture units.
   for (genvar i = 0; i < NUM_MODULES; i++) begin : g_mod
      // Write strobes of this module's window.
      wire sel = wr_mod & (wr_idx == 3'(i));
      wire wr_mode = sel & (wr_sub == `CAC_SUB_MODE);
      wire wr_low = sel & (wr_sub == `CAC_SUB_CAP_LOW);
      wire wr_high = sel & (wr_sub == `CAC_SUB_CAP_HIGH);

      // Mode register of this module.
      always_ff @(posedge sys_clk) begin
         if (reset) begin
            module_mode[i] <= '0;
         end else if (wr_mode) begin
            module_mode[i] <= cac_mode_t'(wbyte[4:0]);
         end
      end

      assign module_int_en[i] = module_mode[i].int_en;

      // Capture unit sees the counter value of the same cycle for every module.
      cac_capture_unit u_unit (
         .sys_clk(sys_clk),
         .reset(reset),
         .module_external_pin(module_external_pin[i]),
         .mode(module_mode[i]),
         .counter(counter),
         .count_tick(count_tick),
         .wr_cap_low(wr_low),
         .wr_cap_high(wr_high),
         .wdata(wbyte),
         .capture(capture[i]),
         .module_event(module_event[i])
      );
   end

   // Shared interrupt: overflow gated by its enable, module flags by their own enables.
   assign counter_array_irq = (counter_overflow_flag & counter_mode_register[`CAC_BIT_OVF_IE]) |
                              (|(module_event_flag & module_int_en));

   // Read decode on the address phase.
   wire [2:0] rd_idx = mod_index(haddr);
   wire [1:0] rd_sub = mod_sub(haddr);
   wire rd_mod = mod_hit(haddr);
   // Control/status read value; the reserved bit reads as zero.
   wire [7:0] ctrl_value = {counter_overflow_flag, counter_run_bit, 1'b0, module_event_flag};
   // Selected module's mode and capture bytes.
   wire [7:0] rd_mode = {3'h0, module_mode[rd_idx]};
   wire [15:0] rd_cap = capture[rd_idx];
   wire [7:0] mod_value = (rd_sub == `CAC_SUB_MODE) ? rd_mode :
                          (rd_sub == `CAC_SUB_CAP_LOW) ? rd_cap[7:0] :
                          (rd_sub == `CAC_SUB_CAP_HIGH) ? rd_cap[15:8] : 8'h00;
   // Byte read of the counter: each half is its own register.
   wire [7:0] rd_byte = (haddr == `CAC_CTRL_ADDR) ? ctrl_value :
                        (haddr == `CAC_CNT_LOW_ADDR) ? counter[7:0] :
                        (haddr == `CAC_CNT_HIGH_ADDR) ? counter[15:8] :
                        (haddr == `CAC_CMODE_ADDR) ? counter_mode_register :
                        rd_mod ? mod_value : 8'h00;
   wire rd_take = addr_take & ~hwrite;
   assign next_hrdata = rd_take ? {24'h000000, rd_byte} : hrdata;

   // Read data register, loaded at the end of the address phase.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         hrdata <= `CAC_RD_ZERO;
      end else begin
         hrdata <= next_hrdata;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   // A read of the low counter byte in its address phase.
   sequence s_read_low;
      addr_take && !hwrite && (haddr == `CAC_CNT_LOW_ADDR);
   endsequence

   // A control write that clears the overflow flag while the counter wraps.
   sequence s_clear_during_wrap;
      wr_ctrl && !hwdata[`CAC_BIT_OVF] && cnt_wrap;
   endsequence

   // The low counter byte alone appears on the bus one cycle later.
   AST_READ_LOW_BYTE: assert property (
      s_read_low |=> (hrdata == {24'h000000, $past(counter[7:0])}))
      else $error("low counter byte read mismatch");

   // A stopped counter with no byte write keeps its value.
   AST_RUN_HOLDS: assert property (
      (!counter_run_bit && !cnt_write) |=> (counter == $past(counter)))
      else $error("counter moved while stopped");

   // A rollover sets the flag and leaves the counter at zero.
   AST_WRAP_SETS_FLAG: assert property (
      cnt_wrap |=> (counter_overflow_flag && (counter == `CAC_CNT_RESET)))
      else $error("rollover did not set overflow flag");

   // Without a control write the overflow flag stays set for at least two cycles.
   AST_OVF_STICKY: assert property (
      (counter_overflow_flag && !wr_ctrl) ##1 !wr_ctrl |-> counter_overflow_flag [*2])
      else $error("overflow flag cleared without software");

   // Hardware set beats a clearing write in the same cycle.
   AST_SET_WINS: assert property (
      s_clear_during_wrap |=> counter_overflow_flag)
      else $error("overflow event lost against a clear");

   // Every module event shows in its flag the next cycle.
   AST_EVENT_FLAG: assert property (
      (module_event != '0) |=> ((module_event_flag & $past(module_event)) == $past(module_event)))
      else $error("module event flag not set");

   // An enabled overflow flag drives the interrupt.
   AST_OVF_IRQ: assert property (
      (counter_overflow_flag && counter_mode_register[`CAC_BIT_OVF_IE]) |-> counter_array_irq)
      else $error("enabled overflow gave no interrupt");

   // A disabled overflow with no enabled module flag keeps the interrupt low.
   AST_OVF_MASKED: assert property (
      (!counter_mode_register[`CAC_BIT_OVF_IE] && !(|(module_event_flag & module_int_en))) |-> !counter_array_irq)
      else $error("interrupt raised while masked");

   // The reserved bit of the control register always reads zero.
   AST_RSVD_ZERO: assert property (
      (addr_take && !hwrite && haddr == `CAC_CTRL_ADDR) |=> !hrdata[`CAC_BIT_RSVD])
      else $error("reserved bit read as one");

   // The control register is all zero right after reset.
   AST_CTRL_RESET: assert property (
      $fell(reset) |-> (ctrl_value == `CAC_CTRL_RESET))
      else $error("control register not zero after reset");

   // A running counter with no byte write moves up by exactly one, wrapping at the top.
   AST_COUNT_STEP: assert property (
      count_tick |=> (counter == $past(counter) + `CAC_CNT_ONE))
      else $error("counter did not step by one");

   // A low-byte write replaces that byte at any time, running or not.
   AST_LOW_BYTE_WRITE: assert property (
      wr_cnt_low |=> (counter[7:0] == $past(wbyte)))
      else $error("counter low byte write lost");

   // The run bit takes the value that software writes.
   AST_RUN_WRITE: assert property (
      wr_ctrl |=> (counter_run_bit == $past(hwdata[`CAC_BIT_RUN])))
      else $error("run bit did not follow the write");

endmodule : cac_top

// File: verification/tb_top.sv
// Self-checking testbench of the counter array control block over its AHB-Lite register port.
`timescale 1ns/1ns
`include "cac_cfg.svh"
module tb_top;
   import cac_pkg::*;

   // Compares a design value with its expectation and counts both the compare and any mismatch.
   `define CHECK(got, exp) begin compares++; if ((got) !== (exp)) begin num_errors++; \
      $display("wrong value at %0t ns: got %h expected %h", $time, (got), (exp)); end end

   // One table row: address, byte written, byte expected back on the following read.
   typedef struct packed {
      logic [31:0] addr;
      logic [7:0] wdata;
      logic [7:0] rd_exp;
   } cac_row_t;

   logic sys_clk = 1'b0; // Bus clock, 8 ns period.
   logic reset = 1'b1; // Synchronous reset, held at start.
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2; // Whole-word transfers only.
   logic [31:0] hwdata = 32'h0000_0000;
   logic hreadyout;
   logic hresp;
   logic [31:0] hrdata;
   logic [4:0] module_external_pin = 5'h1F; // Pins idle high so a falling edge can trigger a snapshot.
   logic counter_array_irq;
   int num_errors = 0; // Mismatches seen.
   int compares = 0; // Comparisons made.
   logic [31:0] rd; // Last read word.
   logic [31:0] base; // Window base of the module under test.
   cac_row_t rows [12]; // Ordinary register cases.

   // Free-running clock.
   always #4 sys_clk = ~sys_clk;

   // The single slave's ready output is the bus ready.
   cac_top #(.NUM_MODULES(5)) i_cac_top (
      .sys_clk(sys_clk),
      .reset(reset),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hwdata(hwdata),
      .hready(hreadyout),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .hrdata(hrdata),
      .module_external_pin(module_external_pin),
      .counter_array_irq(counter_array_irq)
   );

   // Single write: address phase held until ready, then data phase held until ready.
   task automatic bus_write(input logic [31:0] a, input logic [7:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= 1'b1;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h00_0000, d};
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
   endtask : bus_write

   // Single read: the data is taken at the edge that ends the data phase.
   task automatic bus_read(input logic [31:0] a, output logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= 1'b0;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      d = hrdata;
   endtask : bus_read

   // Reads one register and compares its low byte, with the upper bits expected zero.
   task automatic check_read(input logic [31:0] a, input logic [7:0] e);
      bus_read(a, rd);
      `CHECK(rd, {24'h00_0000, e})
      `CHECK(hresp, 1'b0)
   endtask : check_read

   // Samples the interrupt line away from the clock edge.
   task automatic check_irq(input logic e);
      @(negedge sys_clk);
      `CHECK(counter_array_irq, e)
      @(posedge sys_clk);
   endtask : check_irq

   // Prints the counts and the verdict, then ends the run.
   task give_verdict;
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : give_verdict

   // Cuts a hang short; the whole sequence needs well under two thousand cycles.
   initial begin
      repeat (20000) @(posedge sys_clk);
      num_errors++;
      $display("wrong value at %0t ns: watchdog expired", $time);
      give_verdict();
   end

   // Main sequence.
   initial begin
      // Control rows never write a one into the reserved bit.
      rows = '{
         '{`CAC_CTRL_ADDR, 8'h9F, 8'h9F},
         '{`CAC_CTRL_ADDR, 8'h1F, 8'h1F},
         '{`CAC_CTRL_ADDR, 8'h00, 8'h00},
         '{`CAC_CMODE_ADDR, 8'hA5, 8'hA5},
         '{`CAC_CMODE_ADDR, 8'h00, 8'h00},
         '{`CAC_CNT_LOW_ADDR, 8'h5A, 8'h5A},
         '{`CAC_CNT_HIGH_ADDR, 8'hC3, 8'hC3},
         '{`CAC_MOD_BASE + 32'h4, 8'h77, 8'h77},
         '{`CAC_MOD_BASE + 32'h8, 8'h66, 8'h66},
         '{`CAC_MOD_BASE, 8'h0B, 8'h0B},
         '{`CAC_MOD_BASE + 32'hC, 8'hFF, 8'h00},
         '{32'h0000_00F0, 8'hFF, 8'h00}
      };
      repeat (4) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      // Control register, low counter byte and interrupt line read zero after reset.
      check_read(`CAC_CTRL_ADDR, 8'h00);
      check_read(`CAC_CNT_LOW_ADDR, 8'h00);
      check_irq(1'b0);
      // Table of plain write/read cases with the counter stopped.
      foreach (rows[i]) begin
         bus_write(rows[i].addr, rows[i].wdata);
         check_read(rows[i].addr, rows[i].rd_exp);
      end
      bus_write(`CAC_MOD_BASE, 8'h00);
      // Coherent snapshot on every module from a falling pin edge, with a frozen counter value.
      bus_write(`CAC_CNT_LOW_ADDR, 8'h34);
      bus_write(`CAC_CNT_HIGH_ADDR, 8'h12);
      for (int n = 0; n < 5; n++) begin
         base = `CAC_MOD_BASE + 32'(n * 16);
         bus_write(base, 8'h09);
         module_external_pin[n] <= 1'b0;
         repeat (4) @(posedge sys_clk);
         check_read(base + 32'h4, 8'h34);
         check_read(base + 32'h8, 8'h12);
         check_read(`CAC_CTRL_ADDR, 8'(1 << n));
         check_irq(1'b1);
         bus_write(`CAC_CTRL_ADDR, 8'h00);
         check_irq(1'b0);
         // A rising edge is not selected, so no new event may appear.
         module_external_pin[n] <= 1'b1;
         repeat (4) @(posedge sys_clk);
         check_read(`CAC_CTRL_ADDR, 8'h00);
         bus_write(base, 8'h00);
      end
      // Software-timer match on module 1 while the counter runs from zero.
      bus_write(`CAC_CNT_LOW_ADDR, 8'h00);
      bus_write(`CAC_CNT_HIGH_ADDR, 8'h00);
      bus_write(`CAC_MOD_BASE + 32'h14, 8'h40);
      bus_write(`CAC_MOD_BASE + 32'h18, 8'h00);
      bus_write(`CAC_MOD_BASE + 32'h10, 8'h06);
      bus_write(`CAC_CTRL_ADDR, 8'h40);
      repeat (120) @(posedge sys_clk);
      check_read(`CAC_CTRL_ADDR, 8'h42);
      check_irq(1'b0);
      bus_write(`CAC_MOD_BASE + 32'h10, 8'h00);
      bus_write(`CAC_CTRL_ADDR, 8'h00);
      // A stopped counter holds its value.
      bus_write(`CAC_CNT_LOW_ADDR, 8'h55);
      repeat (10) @(posedge sys_clk);
      check_read(`CAC_CNT_LOW_ADDR, 8'h55);
      // Rollover from the top of the count sets the overflow flag and, when enabled, the interrupt.
      bus_write(`CAC_CNT_LOW_ADDR, 8'hF0);
      bus_write(`CAC_CNT_HIGH_ADDR, 8'hFF);
      bus_write(`CAC_CMODE_ADDR, 8'h01);
      bus_write(`CAC_CTRL_ADDR, 8'h40);
      repeat (40) @(posedge sys_clk);
      check_read(`CAC_CTRL_ADDR, 8'hC0);
      check_read(`CAC_CNT_HIGH_ADDR, 8'h00);
      check_irq(1'b1);
      bus_write(`CAC_CTRL_ADDR, 8'h40);
      check_read(`CAC_CTRL_ADDR, 8'h40);
      check_irq(1'b0);
      // Overflow flag set by software, interrupt masked by the enable.
      bus_write(`CAC_CMODE_ADDR, 8'h00);
      bus_write(`CAC_CTRL_ADDR, 8'hC0);
      check_irq(1'b0);
      bus_write(`CAC_CMODE_ADDR, 8'h01);
      check_irq(1'b1);
      // A clearing control write in the very cycle of a rollover loses to the hardware set.
      bus_write(`CAC_CTRL_ADDR, 8'h00);
      bus_write(`CAC_CNT_LOW_ADDR, 8'hFE);
      bus_write(`CAC_CNT_HIGH_ADDR, 8'hFF);
      bus_write(`CAC_CTRL_ADDR, 8'h40);
      bus_write(`CAC_CTRL_ADDR, 8'h40);
      check_read(`CAC_CTRL_ADDR, 8'hC0);
      // A second reset in mid-run clears the running counter and all flags.
      reset <= 1'b1;
      repeat (4) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      check_irq(1'b0);
      check_read(`CAC_CTRL_ADDR, 8'h00);
      check_read(`CAC_CNT_LOW_ADDR, 8'h00);
      check_read(`CAC_CMODE_ADDR, 8'h00);
      give_verdict();
   end
endmodule : tb_top
